// ===== hbfm_pkg.sv
// shared constants and types for the half-bridge fault manager
package hbfm_pkg;
  localparam int unsigned NUM_BRIDGES = 6;
  // avalon register offsets (byte addresses)
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_FREQ      = 8'h04;
  localparam logic [7:0] OFF_GLOBAL    = 8'h08;
  localparam logic [7:0] OFF_OC_FLAGS  = 8'h0c;
  localparam logic [7:0] OFF_OL_FLAGS  = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;
  localparam logic [7:0] OFF_STAGE     = 8'h18;
  // control register field positions
  localparam int unsigned CTL_HS_EN_POS    = 0;
  localparam int unsigned CTL_LS_EN_POS    = 6;
  localparam int unsigned CTL_FW_POS       = 12;
  localparam int unsigned CTL_LOWCUR1_POS  = 18;
  localparam int unsigned CTL_LOWCUR2_POS  = 19;
  localparam int unsigned CTL_ASSIGN_POS   = 20;
  // global status one bit positions
  localparam int unsigned GS_PREWARN_POS   = 1;
  localparam int unsigned GS_TSD_POS       = 2;
  localparam int unsigned GS_OV_POS        = 4;
  localparam int unsigned GS_UV_POS        = 5;
  localparam int unsigned GS_LOAD_POS      = 6;
  // reset values and the stopped frequency code
  localparam logic [31:0] CONTROL_RST      = 32'h0000_0000;
  localparam logic [31:0] FREQ_RST         = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RST     = 32'h0000_0000;
  localparam logic [1:0]  FREQ_STOPPED     = 2'h0;
  // filter times in ns at a 5 ns clock
  localparam int unsigned CLK_PERIOD_NS    = 5;
  localparam int unsigned OC_FILTER_NS     = 10000;
  localparam int unsigned OL_FILTER_NS     = 2000000;
  localparam int unsigned OL_FILTER_LOW_NS = 200000;
  localparam int unsigned OC_FILTER_CYC    = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OL_FILTER_CYC    = (OL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OL_FILTER_LOW_CYC = (OL_FILTER_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W            = 20;

  typedef struct packed {
    logic [5:0] high;
    logic [5:0] low;
  } switch_pair_type;

  typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER} bus_state_type;
endpackage : hbfm_pkg

// ===== half_bridge_fault_manager.sv
// fault protection, diagnosis flags and avalon register file for six half-bridges
`timescale 1ns/100ps
// Operation
// - hs with active freewheel at freq 00 goes low
// - low current mode on switches one, two
// - overcurrent over full filter latches switch off
// - any oc or ol flag sets summary bit
// - switch stays off while oc flag set
// - open load latches flag, output unchanged
// - prewarning latches bit 1, outputs unchanged
// - shutdown temperature latches bit 2, all off
// - undervoltage latches bit 5, auto recovers
// - overvoltage latches bit 4, auto recovers
// - open load blanked for active freewheel stages on running pwm channels
module half_bridge_fault_manager #(
  parameter int unsigned OC_FILTER     = hbfm_pkg::OC_FILTER_CYC,
  parameter int unsigned OL_FILTER     = hbfm_pkg::OL_FILTER_CYC,
  parameter int unsigned OL_FILTER_LOW = hbfm_pkg::OL_FILTER_LOW_CYC
) (
  // clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  // avalon-mm slave
  input  wire logic [7:0]               i_avs_address,
  input  wire logic                     i_avs_read,
  input  wire logic                     i_avs_write,
  input  wire logic [31:0]              i_avs_writedata,
  input  wire logic [3:0]               i_avs_byteenable,
  output logic      [31:0]              o_avs_readdata,
  output logic                          o_avs_waitrequest,
  output logic      [1:0]               o_avs_response,
  // analog comparator pins, asynchronous
  input  wire logic [11:0]              i_overcurrent_pin,
  input  wire logic [11:0]              i_openload_pin,
  input  wire logic [1:0]               i_openload_low_pin,
  input  wire logic                     i_temp_warn_pin,
  input  wire logic                     i_temp_shutdown_pin,
  input  wire logic                     i_supply_under_pin,
  input  wire logic                     i_supply_over_pin,
  // pwm level per channel from the pwm generator, same clock
  input  wire logic [2:0]               i_pwm_level,
  // gate drive and interrupt
  output hbfm_pkg::switch_pair_type     o_gate_on,
  output logic                          o_irq
);
  localparam int unsigned N = hbfm_pkg::NUM_BRIDGES;

  // two-flop synchronisers for every comparator
  logic [29:0] sync1_reg, sync2_reg;
  logic [29:0] raw_in;
  assign raw_in = {i_overcurrent_pin, i_openload_pin, i_openload_low_pin, i_temp_warn_pin,
                   i_temp_shutdown_pin, i_supply_under_pin, i_supply_over_pin};
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 30'h0;
      sync2_reg <= 30'h0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end
  logic [11:0] oc_s, ol_s;
  logic [1:0]  ol_low_s;
  logic        warn_s, tsd_s, uv_s, ov_s;
  assign {oc_s, ol_s, ol_low_s, warn_s, tsd_s, uv_s, ov_s} = sync2_reg;

  // software registers
  logic [31:0] control_reg, control_next;
  logic [31:0] freq_reg, freq_next;
  logic [31:0] mask_reg, mask_next;
  logic [11:0] oc_flag_reg, oc_flag_next;
  logic [11:0] ol_flag_reg, ol_flag_next;
  logic [3:0]  glob_reg, glob_next;   // {uv, ov, tsd, prewarn}
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  resp_reg, resp_next;
  hbfm_pkg::bus_state_type bus_state_reg, bus_state_next;

  // decoded control fields
  logic [5:0]  hs_en, ls_en, fw_active;
  logic [1:0]  low_cur_sel;
  assign hs_en       = control_reg[hbfm_pkg::CTL_HS_EN_POS +: 6];
  assign ls_en       = control_reg[hbfm_pkg::CTL_LS_EN_POS +: 6];
  assign fw_active   = control_reg[hbfm_pkg::CTL_FW_POS +: 6];
  assign low_cur_sel = {control_reg[hbfm_pkg::CTL_LOWCUR2_POS], control_reg[hbfm_pkg::CTL_LOWCUR1_POS]};

  // channel 1..3 per bridge, 0 means continuous drive
  function automatic logic [1:0] assign_of(input logic [31:0] ctl, input int unsigned b);
    assign_of = ctl[hbfm_pkg::CTL_ASSIGN_POS + 2*b +: 2];
  endfunction : assign_of
  function automatic logic [1:0] freq_of(input logic [31:0] fr, input logic [1:0] ch);
    freq_of = (ch == 2'h0) ? 2'h0 : fr[2*(ch-2'h1) +: 2];
  endfunction : freq_of

  // global stop: temperature latch or live supply fault
  logic all_off;
  assign all_off = glob_reg[1] | uv_s | ov_s;

  hbfm_pkg::switch_pair_type drive_next, drive_reg;
  logic [11:0] stage_active;   // {low, high} active switch used for open-load arming
  logic [11:0] ol_blank;
  always_comb begin
    drive_next = '0;
    ol_blank   = '0;
    for (int b = 0; b < N; b++) begin
      logic [1:0] ch;
      logic [1:0] fq;
      logic       pwm_on;
      ch = assign_of(control_reg, b);
      fq = freq_of(freq_reg, ch);
      pwm_on = (ch != 2'h0) && (fq != hbfm_pkg::FREQ_STOPPED);
      if (ch == 2'h0) begin
        drive_next.high[b] = hs_en[b];
        drive_next.low[b]  = ls_en[b];
      end else if (fq == hbfm_pkg::FREQ_STOPPED) begin
        // stopped channel: an enabled high switch with freewheel hands the bridge to its low partner
        drive_next.high[b] = hs_en[b] & ~fw_active[b];
        drive_next.low[b]  = ls_en[b] | (hs_en[b] & fw_active[b]);
      end else begin
        drive_next.high[b] = hs_en[b] ? i_pwm_level[ch-2'h1]
                                      : (ls_en[b] & fw_active[b] & ~i_pwm_level[ch-2'h1]);
        drive_next.low[b]  = ls_en[b] ? i_pwm_level[ch-2'h1]
                                      : (hs_en[b] & fw_active[b] & ~i_pwm_level[ch-2'h1]);
      end
      // freewheeling partner sees no load current by design
      ol_blank[b]     = pwm_on & fw_active[b] & ~hs_en[b];
      ol_blank[b + N] = pwm_on & fw_active[b] & ~ls_en[b];
      // forced off without touching control_reg
      if (oc_flag_reg[b] || all_off) drive_next.high[b] = 1'b0;
      if (oc_flag_reg[b + N] || all_off) drive_next.low[b] = 1'b0;
      if (drive_next.high[b]) drive_next.low[b] = 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) drive_reg <= '0;
    else          drive_reg <= drive_next;
  end
  assign o_gate_on    = drive_reg;
  assign stage_active = {drive_reg.low, drive_reg.high};

  // per-switch filters, generated
  logic [11:0] oc_fire, ol_fire;
  genvar g;
  generate
    for (g = 0; g < 2*N; g++) begin : g_filter
      logic [hbfm_pkg::CNT_W-1:0] oc_cnt_reg, oc_cnt_next, ol_cnt_reg, ol_cnt_next;
      logic                       ol_cond;
      logic [hbfm_pkg::CNT_W-1:0] ol_limit;
      if (g < 2) begin : g_low
        assign ol_cond  = low_cur_sel[g] ? ol_low_s[g] : ol_s[g];
        assign ol_limit = low_cur_sel[g] ? hbfm_pkg::CNT_W'(OL_FILTER_LOW) : hbfm_pkg::CNT_W'(OL_FILTER);
      end else begin : g_std
        assign ol_cond  = ol_s[g];
        assign ol_limit = hbfm_pkg::CNT_W'(OL_FILTER);
      end
      always_comb begin
        // current below threshold restarts the count
        oc_cnt_next = (stage_active[g] && oc_s[g] && !oc_flag_reg[g])
                      ? oc_cnt_reg + 1'b1 : '0;
        ol_cnt_next = (stage_active[g] && ol_cond && !ol_blank[g] && !ol_flag_reg[g])
                      ? ol_cnt_reg + 1'b1 : '0;
      end
      assign oc_fire[g] = (oc_cnt_reg == hbfm_pkg::CNT_W'(OC_FILTER) - 1'b1) && oc_cnt_next != '0;
      assign ol_fire[g] = (ol_cnt_reg == ol_limit - 1'b1) && ol_cnt_next != '0;
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          oc_cnt_reg <= '0;
          ol_cnt_reg <= '0;
        end else begin
          oc_cnt_reg <= oc_fire[g] ? '0 : oc_cnt_next;
          ol_cnt_reg <= ol_fire[g] ? '0 : ol_cnt_next;
        end
      end
    end
  endgenerate

  // register access and sticky flags
  logic rd_hit, wr_hit, known;
  assign known = (i_avs_address == hbfm_pkg::OFF_CONTROL) || (i_avs_address == hbfm_pkg::OFF_FREQ) ||
                 (i_avs_address == hbfm_pkg::OFF_GLOBAL) || (i_avs_address == hbfm_pkg::OFF_OC_FLAGS) ||
                 (i_avs_address == hbfm_pkg::OFF_OL_FLAGS) || (i_avs_address == hbfm_pkg::OFF_IRQ_MASK) ||
                 (i_avs_address == hbfm_pkg::OFF_STAGE);
  assign rd_hit = (bus_state_reg == hbfm_pkg::BUS_IDLE) && i_avs_read;
  assign wr_hit = (bus_state_reg == hbfm_pkg::BUS_IDLE) && i_avs_write;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    for (int i = 0; i < 4; i++) be_merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
  endfunction : be_merge

  logic [31:0] global_view;
  logic        load_sum;
  assign load_sum    = |{oc_flag_reg, ol_flag_reg};
  assign global_view = {25'h0, load_sum, glob_reg[3], glob_reg[2], 1'b0, glob_reg[1], glob_reg[0], 1'b0};

  always_comb begin
    control_next   = control_reg;
    freq_next      = freq_reg;
    mask_next      = mask_reg;
    oc_flag_next   = oc_flag_reg;
    ol_flag_next   = ol_flag_reg;
    glob_next      = glob_reg;
    rdata_next     = rdata_reg;
    resp_next      = resp_reg;
    bus_state_next = hbfm_pkg::BUS_IDLE;
    if (rd_hit || wr_hit) begin
      bus_state_next = hbfm_pkg::BUS_ANSWER;
      resp_next      = known ? 2'h0 : 2'h3;
      rdata_next     = 32'h0;
    end
    if (wr_hit) begin
      unique case (i_avs_address)
        hbfm_pkg::OFF_CONTROL:  control_next = be_merge(control_reg, i_avs_writedata, i_avs_byteenable);
        hbfm_pkg::OFF_FREQ:     freq_next = be_merge(freq_reg, i_avs_writedata, i_avs_byteenable) & 32'h3f;
        hbfm_pkg::OFF_IRQ_MASK: mask_next = be_merge(mask_reg, i_avs_writedata, i_avs_byteenable);
        // write one to clear, rearming the detectors
        hbfm_pkg::OFF_OC_FLAGS: oc_flag_next = oc_flag_reg & ~i_avs_writedata[11:0];
        hbfm_pkg::OFF_OL_FLAGS: ol_flag_next = ol_flag_reg & ~i_avs_writedata[11:0];
        hbfm_pkg::OFF_GLOBAL:   glob_next = glob_reg & ~{i_avs_writedata[hbfm_pkg::GS_UV_POS],
                                  i_avs_writedata[hbfm_pkg::GS_OV_POS], i_avs_writedata[hbfm_pkg::GS_TSD_POS],
                                  i_avs_writedata[hbfm_pkg::GS_PREWARN_POS]};
        default: ;
      endcase
    end
    if (rd_hit) begin
      unique case (i_avs_address)
        hbfm_pkg::OFF_CONTROL:  rdata_next = control_reg;
        hbfm_pkg::OFF_FREQ:     rdata_next = freq_reg;
        hbfm_pkg::OFF_IRQ_MASK: rdata_next = mask_reg;
        hbfm_pkg::OFF_OC_FLAGS: rdata_next = {20'h0, oc_flag_reg};
        hbfm_pkg::OFF_OL_FLAGS: rdata_next = {20'h0, ol_flag_reg};
        hbfm_pkg::OFF_STAGE:    rdata_next = {20'h0, drive_reg.low, drive_reg.high};
        hbfm_pkg::OFF_GLOBAL: begin
          rdata_next = global_view;
          glob_next  = 4'h0;   // read clears status
        end
        default: ;
      endcase
    end
    // hardware set wins over any clear
    oc_flag_next = oc_flag_next | oc_fire;
    ol_flag_next = ol_flag_next | ol_fire;
    glob_next    = glob_next | {uv_s, ov_s, tsd_s, warn_s};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control_reg   <= hbfm_pkg::CONTROL_RST;
      freq_reg      <= hbfm_pkg::FREQ_RST;
      mask_reg      <= hbfm_pkg::IRQ_MASK_RST;
      oc_flag_reg   <= 12'h0;
      ol_flag_reg   <= 12'h0;
      glob_reg      <= 4'h0;
      rdata_reg     <= 32'h0;
      resp_reg      <= 2'h0;
      bus_state_reg <= hbfm_pkg::BUS_IDLE;
    end else begin
      control_reg   <= control_next;
      freq_reg      <= freq_next;
      mask_reg      <= mask_next;
      oc_flag_reg   <= oc_flag_next;
      ol_flag_reg   <= ol_flag_next;
      glob_reg      <= glob_next;
      rdata_reg     <= rdata_next;
      resp_reg      <= resp_next;
      bus_state_reg <= bus_state_next;
    end
  end

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (bus_state_reg == hbfm_pkg::BUS_IDLE);
  assign o_avs_readdata    = rdata_reg;
  assign o_avs_response    = resp_reg;
  assign o_irq             = |(global_view & mask_reg);

  // assertions
  AST_OC_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    oc_flag_reg[0] |=> !o_gate_on.high[0]) else $error("switch on while overcurrent flag set");
  AST_OC_FILTER: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(oc_flag_reg[0]) |-> $past(oc_fire[0])) else $error("overcurrent flag set without filter");
  // checked at the bus, so a broken read path trips it too
  AST_SUMMARY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rd_hit && i_avs_address == hbfm_pkg::OFF_GLOBAL && (|{oc_flag_reg, ol_flag_reg}))
    |=> o_avs_readdata[hbfm_pkg::GS_LOAD_POS]) else $error("summary missing");
  AST_TSD_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    glob_reg[1] |=> o_gate_on == '0) else $error("output on during thermal shutdown");
  AST_UV_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    uv_s |=> o_gate_on == '0) else $error("output on during undervoltage");
  AST_OV_FLAG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ov_s |=> glob_reg[2]) else $error("overvoltage flag not latched");
  AST_WARN_FLAG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    warn_s |=> glob_reg[0]) else $error("prewarning flag not latched");
  AST_CTRL_KEPT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !wr_hit |=> control_reg == $past(control_reg)) else $error("control changed without write");
  AST_OC_ABORT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !oc_s[0] |=> g_filter[0].oc_cnt_reg == '0) else $error("filter kept counting");
  AST_OL_BLANK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ol_blank[6] |=> g_filter[6].ol_cnt_reg == '0) else $error("open load counted while blanked");
  AST_FW_STOP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (assign_of(control_reg, 0) != 2'h0 && freq_of(freq_reg, assign_of(control_reg, 0)) == hbfm_pkg::FREQ_STOPPED
     && hs_en[0] && fw_active[0] && !all_off && !oc_flag_reg[6])
    |=> (o_gate_on.low[0] && !o_gate_on.high[0])) else $error("stopped freewheel channel not handed to low switch");
endmodule : half_bridge_fault_manager

// ===== hbfm_host.sv
// avalon-mm master standing in for the host microcontroller
`timescale 1ns/100ps
module hbfm_host (
  // clock
  input  wire logic        i_clk,
  // avalon-mm master side
  output logic [7:0]       o_address,
  output logic             o_read,
  output logic             o_write,
  output logic [31:0]      o_writedata,
  input  wire logic [31:0] i_readdata,
  input  wire logic        i_waitrequest,
  input  wire logic [1:0]  i_response
);
  initial begin
    o_address   = 8'h00;
    o_read      = 1'b0;
    o_write     = 1'b0;
    o_writedata = 32'h0000_0000;
  end

  // request held until waitrequest is seen low at a rising edge
  task automatic access(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic [1:0] rsp);
    @(posedge i_clk);
    o_address   <= adr;
    o_writedata <= wd;
    o_write     <= wr;
    o_read      <= ~wr;
    @(posedge i_clk);
    while (i_waitrequest !== 1'b0) @(posedge i_clk);
    rd = i_readdata;
    rsp = i_response;
    o_read      <= 1'b0;
    o_write     <= 1'b0;
    // released data must not look like the last value
    o_writedata <= ~wd;
  endtask : access

  // write one to clear; only a cleared flag lets a tripped switch back on
  task automatic clear_flags(input logic [7:0] adr, input logic [31:0] bits);
    logic [31:0] d;
    logic [1:0]  r;
    access(1'b1, adr, bits, d, r);
  endtask : clear_flags
endmodule : hbfm_host

// ===== test_half_bridge_fault_manager.sv
// self-checking bench for the half-bridge fault manager
`timescale 1ns/100ps
module test_half_bridge_fault_manager;
  logic                      i_clk = 1'b0;
  logic                      i_rst_n = 1'b0;
  logic [7:0]                adr;
  logic                      rd_en;
  logic                      wr_en;
  logic [31:0]               wdat;
  logic [31:0]               rdat;
  logic                      wait_req;
  logic [1:0]                resp;
  logic [11:0]               oc_pin = 12'h000;
  logic [11:0]               ol_pin = 12'h000;
  logic [1:0]                ol_low_pin = 2'h0;
  logic                      warn_pin = 1'b0;
  logic                      tsd_pin = 1'b0;
  logic                      uv_pin = 1'b0;
  logic                      ov_pin = 1'b0;
  logic [2:0]                pwm = 3'h0;
  hbfm_pkg::switch_pair_type gate;
  logic                      irq;
  int                        miscompares = 0;
  int                        cmp_count = 0;
  int                        cycles = 0;
  logic [31:0]               ctl_model;
  logic [31:0]               d;
  logic [1:0]                r;

  half_bridge_fault_manager #(.OC_FILTER(8), .OL_FILTER(20), .OL_FILTER_LOW(5)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd_en), .i_avs_write(wr_en),
    .i_avs_writedata(wdat), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_req),
    .o_avs_response(resp), .i_overcurrent_pin(oc_pin), .i_openload_pin(ol_pin),
    .i_openload_low_pin(ol_low_pin), .i_temp_warn_pin(warn_pin), .i_temp_shutdown_pin(tsd_pin),
    .i_supply_under_pin(uv_pin), .i_supply_over_pin(ov_pin), .i_pwm_level(pwm), .o_gate_on(gate), .o_irq(irq));
  hbfm_host host (.i_clk(i_clk), .o_address(adr), .o_read(rd_en), .o_write(wr_en), .o_writedata(wdat),
    .i_readdata(rdat), .i_waitrequest(wait_req), .i_response(resp));

  always #2.5 i_clk = ~i_clk;

  // enabled switches as gate commands, {high, low}
  function automatic logic [11:0] gate_of(input logic [31:0] c);
    return {c[5:0], c[11:6]};
  endfunction : gate_of

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    host.access(1'b0, a, 32'h0, d, r);
    chk(what, d, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.access(1'b1, a, v, d, r);
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc

  // bounded wait: synchroniser and register latency are not pinned down to the cycle
  task automatic wait_gate(input logic [11:0] exp, input int max, input string what);
    for (int i = 0; i < max && gate !== exp; i++) @(posedge i_clk);
    chk(what, 32'(gate), 32'(exp));
  endtask : wait_gate

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(18396));
    ctl_model = 32'h0000_0101;
    cyc(2);
    i_rst_n <= 1'b1;
    rd(hbfm_pkg::OFF_CONTROL, hbfm_pkg::CONTROL_RST, "control reset");
    rd(hbfm_pkg::OFF_IRQ_MASK, hbfm_pkg::IRQ_MASK_RST, "mask reset");
    rd(hbfm_pkg::OFF_GLOBAL, 32'h0, "global reset");
    rd(8'hfc, 32'h0, "unmapped data");
    chk("unmapped response", 32'(r), 32'h3);
    wr(hbfm_pkg::OFF_CONTROL, ctl_model);
    wait_gate(gate_of(ctl_model), 5, "gates on");
    $display("reset test done");
    // a burst shorter than the filter leaves no trace
    oc_pin[0] <= 1'b1;
    cyc(1 + int'($urandom % 5));
    oc_pin[0] <= 1'b0;
    cyc(12);
    chk("short overcurrent", 32'(gate), 32'(gate_of(ctl_model)));
    rd(hbfm_pkg::OFF_OC_FLAGS, 32'h0, "short overcurrent flag");
    // second pass shows the cleared flag re-arms detection
    for (int k = 0; k < 2; k++) begin
      oc_pin[0] <= 1'b1;
      cyc(6);
      chk("overcurrent in filter", 32'(gate), 32'(gate_of(ctl_model)));
      wait_gate(gate_of(ctl_model) & ~12'h040, 12, "overcurrent off");
      oc_pin[0] <= 1'b0;
      cyc(10);
      chk("overcurrent stays off", 32'(gate), 32'(gate_of(ctl_model) & ~12'h040));
      rd(hbfm_pkg::OFF_OC_FLAGS, 32'h1, "overcurrent flag");
      rd(hbfm_pkg::OFF_GLOBAL, 32'h40, "load summary");
      rd(hbfm_pkg::OFF_CONTROL, ctl_model, "control kept");
      host.clear_flags(hbfm_pkg::OFF_OC_FLAGS, 32'h1);
      wait_gate(gate_of(ctl_model), 5, "overcurrent recovered");
      rd(hbfm_pkg::OFF_GLOBAL, 32'h0, "load summary cleared");
    end
    $display("overcurrent test done");
    ol_pin[8] <= 1'b1;
    cyc(30);
    ol_pin[8] <= 1'b0;
    chk("open load output", 32'(gate), 32'(gate_of(ctl_model)));
    rd(hbfm_pkg::OFF_OL_FLAGS, 32'h100, "open load flag");
    rd(hbfm_pkg::OFF_GLOBAL, 32'h40, "open load summary");
    host.clear_flags(hbfm_pkg::OFF_OL_FLAGS, 32'h100);
    // both low current selects, with the second high switch switched on too
    ctl_model[19:18] = 2'h3;
    ctl_model[1] = 1'b1;
    wr(hbfm_pkg::OFF_CONTROL, ctl_model);
    // twelve cycles is well below the normal filter
    ol_low_pin <= 2'h3;
    cyc(12);
    ol_low_pin <= 2'h0;
    rd(hbfm_pkg::OFF_OL_FLAGS, 32'h3, "low current open load");
    host.clear_flags(hbfm_pkg::OFF_OL_FLAGS, 32'h3);
    rd(hbfm_pkg::OFF_OL_FLAGS, 32'h0, "open load cleared");
    $display("open load test done");
    wr(hbfm_pkg::OFF_IRQ_MASK, 32'h4);
    warn_pin <= 1'b1;
    cyc(4);
    warn_pin <= 1'b0;
    cyc(4);
    chk("prewarning output", 32'(gate), 32'(gate_of(ctl_model)));
    chk("prewarning masked irq", 32'(irq), 32'h0);
    rd(hbfm_pkg::OFF_GLOBAL, 32'h2, "prewarning");
    rd(hbfm_pkg::OFF_GLOBAL, 32'h0, "prewarning read clear");
    tsd_pin <= 1'b1;
    cyc(4);
    tsd_pin <= 1'b0;
    wait_gate(12'h000, 6, "shutdown off");
    cyc(10);
    chk("shutdown latched", 32'(gate), 32'h0);
    chk("shutdown irq", 32'(irq), 32'h1);
    rd(hbfm_pkg::OFF_CONTROL, ctl_model, "control kept shutdown");
    rd(hbfm_pkg::OFF_GLOBAL, 32'h4, "shutdown flag");
    wait_gate(gate_of(ctl_model), 5, "shutdown cleared");
    cyc(2);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("temperature test done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) uv_pin <= 1'b1;
      else ov_pin <= 1'b1;
      wait_gate(12'h000, 8, "supply off");
      rd(hbfm_pkg::OFF_GLOBAL, (k == 0) ? 32'h20 : 32'h10, "supply flag");
      uv_pin <= 1'b0;
      ov_pin <= 1'b0;
      wait_gate(gate_of(ctl_model), 8, "supply recovered");
      rd(hbfm_pkg::OFF_GLOBAL, (k == 0) ? 32'h20 : 32'h10, "supply flag kept");
      rd(hbfm_pkg::OFF_GLOBAL, 32'h0, "supply flag cleared");
    end
    $display("supply test done");
    wr(hbfm_pkg::OFF_FREQ, 32'h0);
    ctl_model = 32'h0010_1001;
    wr(hbfm_pkg::OFF_CONTROL, ctl_model);
    wait_gate(12'h001, 5, "freewheel stopped");
    wr(hbfm_pkg::OFF_FREQ, 32'h1);
    ol_pin[6] <= 1'b1;
    repeat (40) begin
      @(posedge i_clk);
      // channel one stays low so the freewheel partner conducts through the whole filter window
      pwm <= 3'($urandom) & 3'h6;
    end
    ol_pin[6] <= 1'b0;
    chk("freewheel partner on", 32'(gate), 32'h001);
    rd(hbfm_pkg::OFF_OL_FLAGS, 32'h0, "freewheel open load blanked");
    $display("freewheel test done");
    report_and_stop();
  end
endmodule : test_half_bridge_fault_manager
